// File: design/ofmc_baud_detect.v
// Boot serial receiver with automatic bit-rate measurement.
// Assumes rx_in is already synchronised; host sends H'55 first.
`timescale 1ns/1ps
`include "ofmc_defs.vh"

module ofmc_baud_detect (
  input wire core_clk_in,
  input wire srst_in,
  input wire clk_en_in,
  input wire enable_in,
  input wire rx_in,
  output reg [15:0] period_out,
  output reg locked_out,
  output reg [7:0] byte_out,
  output reg byte_valid_out,
  output reg tx_out
);
  localparam B_HUNT = 5'b00001;
  localparam B_MEAS = 5'b00010;
  localparam B_GUARD = 5'b00100;
  localparam B_IDLE = 5'b01000;
  localparam B_RX = 5'b10000;

  reg [4:0] st_reg;
  reg [19:0] cnt_reg;
  reg [3:0] bit_reg;
  reg [7:0] sh_reg;
  reg tx_go_reg;
  reg [9:0] tx_sh_reg;
  reg [3:0] tx_bit_reg;
  reg [15:0] tx_cnt_reg;
  wire [19:0] guard_len = {period_out, 4'h0};

  // ========================================
  // Bit-rate measurement and receiver
  always @(posedge core_clk_in) begin
    if (srst_in) begin
      st_reg <= B_HUNT;
      cnt_reg <= 20'h00000;
      bit_reg <= 4'h0;
      sh_reg <= 8'h00;
      period_out <= 16'h0000;
      locked_out <= 1'b0;
      byte_out <= 8'h00;
      byte_valid_out <= 1'b0;
      tx_go_reg <= 1'b0;
    end else if (clk_en_in) begin
      byte_valid_out <= 1'b0;
      tx_go_reg <= 1'b0;
      case (st_reg)
        B_HUNT: if (enable_in && !rx_in) begin
          st_reg <= B_MEAS;
          cnt_reg <= 20'h00001;
        end
        // Start bit of H'55 is exactly one bit time long
        B_MEAS: if (rx_in) begin
          period_out <= cnt_reg[15:0]; // R14
          locked_out <= 1'b1;
          cnt_reg <= 20'h00000;
          st_reg <= B_GUARD;
        end else if (cnt_reg[15:0] != `OFMC_BAUD_MAX) begin
          cnt_reg <= cnt_reg + 20'h00001;
        end
        // Wait out the rest of the calibration byte
        B_GUARD: if (!rx_in) begin
          cnt_reg <= 20'h00000;
        end else if (cnt_reg >= guard_len) begin
          st_reg <= B_IDLE;
          tx_go_reg <= 1'b1; // R14
        end else begin
          cnt_reg <= cnt_reg + 20'h00001;
        end
        B_IDLE: if (!rx_in) begin
          cnt_reg <= {5'h00, period_out[15:1]};
          bit_reg <= 4'h0;
          st_reg <= B_RX;
        end
        B_RX: if (cnt_reg != 20'h00000) begin
          cnt_reg <= cnt_reg - 20'h00001;
        end else begin
          cnt_reg <= {4'h0, period_out} - 20'h00001;
          if (bit_reg == 4'h0) begin
            if (rx_in) st_reg <= B_IDLE;
            else bit_reg <= 4'h1;
          end else if (bit_reg <= 4'h8) begin
            sh_reg <= {rx_in, sh_reg[7:1]};
            bit_reg <= bit_reg + 4'h1;
          end else begin
            byte_out <= sh_reg; // R13
            byte_valid_out <= rx_in;
            st_reg <= B_IDLE;
          end
        end
        default: st_reg <= B_HUNT;
      endcase
    end
  end

  // ========================================
  // Acknowledge byte sent at the measured rate
  always @(posedge core_clk_in) begin
    if (srst_in) begin
      tx_out <= 1'b1;
      tx_sh_reg <= 10'h3ff;
      tx_bit_reg <= 4'h0;
      tx_cnt_reg <= 16'h0000;
    end else if (clk_en_in) begin
      if (tx_go_reg) begin
        tx_sh_reg <= {1'b1, `OFMC_ACK_BYTE, 1'b0};
        tx_bit_reg <= 4'ha;
        tx_cnt_reg <= 16'h0000;
      end else if (tx_bit_reg != 4'h0) begin
        if (tx_cnt_reg == 16'h0000) begin
          tx_out <= tx_sh_reg[0];
          tx_sh_reg <= {1'b1, tx_sh_reg[9:1]};
          tx_bit_reg <= tx_bit_reg - 4'h1;
          tx_cnt_reg <= period_out - 16'h0001;
        end else begin
          tx_cnt_reg <= tx_cnt_reg - 16'h0001;
        end
      end
    end
  end
endmodule // ofmc_baud_detect

// File: design/ofmc_defs.vh
// Constants for the on-chip flash mode controller.
// Assumes a 25 MHz core clock and a 20-bit Avalon byte address.
`ifndef OFMC_DEFS_VH
`define OFMC_DEFS_VH
// ========================================
// Timing
`define OFMC_CLK_NS 40
`define OFMC_SETTLE_NS 10000
`define OFMC_SETTLE_CYC ((`OFMC_SETTLE_NS+`OFMC_CLK_NS-1)/`OFMC_CLK_NS)
`define OFMC_FRD_LAT 3'h2
// ========================================
// Address map
`define OFMC_REG_SPACE_BIT 19
`define OFMC_BRAM_BIT 10
`define OFMC_OFS_FMC1 8'h00
`define OFMC_OFS_EBLK 8'h04
`define OFMC_OFS_RAMEMU 8'h08
`define OFMC_OFS_STAT 8'h0c
`define OFMC_OFS_SERRX 8'h10
`define OFMC_OFS_BAUD 8'h14
`define OFMC_4K_REGION 3'h7
`define OFMC_32K_REGION 3'h6
// ========================================
// flash_mode_control_1 fields
`define OFMC_B_P 0
`define OFMC_B_E 1
`define OFMC_B_PV 2
`define OFMC_B_EV 3
`define OFMC_B_PSU 4
`define OFMC_B_ESU 5
`define OFMC_B_SWE 6
`define OFMC_FMC1_RST 7'h00
// ========================================
// Other fields and values
`define OFMC_RAMEMU_RST 8'hf0
`define OFMC_OVERLAP_SELECT_BIT 3
`define OFMC_EBLK_RST 12'h000
`define OFMC_EBLK_ALL 12'hfff
`define OFMC_ERASED_WORD 32'hffffffff
`define OFMC_MD_BOOT 3'h5
`define OFMC_PAGE_LAST 5'h1f
`define OFMC_ACK_BYTE 8'h00
`define OFMC_BAUD_MAX 16'hffff
`endif

// File: design/ofmc_top.v
// Flash mode control: Avalon-MM registers, protection, program/erase
// sequencing, RAM overlay and boot serial loader.
// Assumes an external 256-kbyte array with fixed read latency.
`timescale 1ns/1ps
`include "ofmc_defs.vh"

// Contract
// R1 - 256-kbyte array readable in every mode
// R2 - Program, erase, program-verify, erase-verify modes
// R3 - Programming writes 128 bytes at once
// R4 - Erase acts on exactly one block
// R5 - Blocks: three 64k, one 32k, eight 4k
// R6 - Erased locations read as H'FF
// R7 - Operating mode latched from pins at reset
// R8 - User mode reads only, no program/erase
// R9 - Write-enable pin level switches user/programming mode
// R10 - Software clears control bits, waits, then toggles
// R11 - Write-enable pin low blocks program and erase
// R12 - Boot erases whole array; no block erase
// R13 - Boot loader receives program into RAM serially
// R14 - Boot serial rate matches host bit rate
// R15 - Overlay redirects chosen block to overlap RAM
// R16 - Clearing overlap select restores flash access
// R17 - Software uses overlay only in user modes
// R18 - Bit writes gated by enables and setup
// R19 - Control register resets H'80 or H'00
// R20 - Mode changes held off for settling count
module ofmc_top (
  input wire core_clk_in,
  input wire srst_in,
  input wire clk_en_in,
  input wire flash_write_enable_pin_in,
  input wire mode_select_bit2_in,
  input wire mode_select_bit1_in,
  input wire mode_select_bit0_in,
  input wire serial_rx_in,
  output wire serial_tx_out,
  input wire [19:0] avs_address_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [31:0] avs_writedata_in,
  input wire [3:0] avs_byteenable_in,
  output reg [31:0] avs_readdata_out,
  output reg avs_waitrequest_out,
  output reg flash_rd_out,
  output reg flash_wr_out,
  output reg [17:0] flash_addr_out,
  output reg [31:0] flash_wdata_out,
  input wire [31:0] flash_rdata_in,
  output reg flash_erase_out,
  output reg [11:0] flash_erase_blocks_out,
  output reg [3:0] flash_op_mode_out,
  output reg [2:0] run_mode_out
);
  localparam S_IDLE = 4'b0001;
  localparam S_FRD = 4'b0010;
  localparam S_ACK = 4'b0100;
  localparam S_PROG = 4'b1000;
  localparam M_USER = 3'b001;
  localparam M_UPROG = 3'b010;
  localparam M_BOOT = 3'b100;

  // ========================================
  // Pin synchronisers
  reg [1:0] fwe_sy;
  reg [1:0] md2_sy;
  reg [1:0] md1_sy;
  reg [1:0] md0_sy;
  reg [1:0] rx_sy;

  always @(posedge core_clk_in) begin
    if (clk_en_in) begin
      fwe_sy <= {fwe_sy[0], flash_write_enable_pin_in};
      md2_sy <= {md2_sy[0], mode_select_bit2_in};
      md1_sy <= {md1_sy[0], mode_select_bit1_in};
      md0_sy <= {md0_sy[0], mode_select_bit0_in};
      rx_sy <= {rx_sy[0], serial_rx_in};
    end
  end

  wire flash_write_enable_pin = fwe_sy[1];
  wire [2:0] md = {md2_sy[1], md1_sy[1], md0_sy[1]};

  // ========================================
  // State
  reg [3:0] state_reg;
  reg [2:0] run_mode_reg;
  reg fwe_seen_reg;
  reg [6:0] fmc_reg;
  reg [6:0] fmc_next;
  reg [11:0] eblk_reg;
  reg [7:0] ramemu_reg;
  reg [11:0] settle_reg;
  reg p_prev_reg;
  reg e_prev_reg;
  reg boot_erased_reg;
  reg [10:0] page_addr_reg;
  reg [4:0] cnt_reg;
  reg [7:0] rxd_reg;
  reg rxv_reg;
  reg [7:0] bptr_reg;
  reg [31:0] reg_rdata;
  reg [31:0] page_buf [0:31];
  reg [31:0] ovl_ram [0:1023];
  reg [7:0] boot_ram [0:255];

  wire [15:0] period;
  wire locked;
  wire [7:0] rx_byte;
  wire rx_valid;

  wire is_user = run_mode_reg[0];
  wire is_boot = run_mode_reg[2];
  wire software_write_enable = fmc_reg[`OFMC_B_SWE];
  wire idle = state_reg[0];
  wire req = avs_read_in | avs_write_in;
  wire in_reg = avs_address_in[`OFMC_REG_SPACE_BIT];
  wire in_bram = avs_address_in[`OFMC_BRAM_BIT];
  wire [7:0] rofs = avs_address_in[7:0];
  wire [7:0] wd = avs_writedata_in[7:0];
  wire wr_lo = avs_write_in & avs_byteenable_in[0] & in_reg & ~in_bram;
  wire settle_ok = settle_reg >= `OFMC_SETTLE_CYC;
  wire p_rise = fmc_reg[`OFMC_B_P] & ~p_prev_reg;
  wire e_rise = fmc_reg[`OFMC_B_E] & ~e_prev_reg;
  wire p_go = idle & p_rise & (~is_boot | boot_erased_reg);
  wire bus_go = idle & req & ~p_go;
  wire fl_acc = bus_go & ~in_reg;
  wire [17:0] faddr = avs_address_in[17:0];
  wire ovl_hit = ramemu_reg[`OFMC_OVERLAP_SELECT_BIT] &
    (faddr[17:15] == `OFMC_4K_REGION) &
    (faddr[14:12] == ramemu_reg[2:0]); // R15 R16
  wire [9:0] ovl_idx = faddr[11:2];
  wire [4:0] pg_idx = faddr[6:2];
  wire eblk_one = (eblk_reg != `OFMC_EBLK_RST) &&
    ((eblk_reg & (eblk_reg - 12'h001)) == `OFMC_EBLK_RST);

  function [31:0] lane_merge;
    input [31:0] old_w;
    input [31:0] new_w;
    input [3:0] be;
    integer i;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        lane_merge[i*8 +: 8] = be[i] ? new_w[i*8 +: 8] : old_w[i*8 +: 8];
      end
    end
  endfunction

  // ========================================
  // Boot serial loader
  ofmc_baud_detect u_baud (
    .core_clk_in(core_clk_in),
    .srst_in(srst_in),
    .clk_en_in(clk_en_in),
    .enable_in(is_boot),
    .rx_in(rx_sy[1]),
    .period_out(period),
    .locked_out(locked),
    .byte_out(rx_byte),
    .byte_valid_out(rx_valid),
    .tx_out(serial_tx_out)
  );

  // ========================================
  // Control register write gating
  always @* begin
    fmc_next = fmc_reg;
    if (bus_go && wr_lo && rofs == `OFMC_OFS_FMC1) begin
      if (flash_write_enable_pin && !is_user) fmc_next[`OFMC_B_SWE] = wd[`OFMC_B_SWE]; // R18 R8
      if (flash_write_enable_pin && software_write_enable) begin
        fmc_next[`OFMC_B_ESU] = wd[`OFMC_B_ESU]; // R18
        fmc_next[`OFMC_B_PSU] = wd[`OFMC_B_PSU];
        fmc_next[`OFMC_B_EV] = wd[`OFMC_B_EV];
        fmc_next[`OFMC_B_PV] = wd[`OFMC_B_PV];
      end
      if (flash_write_enable_pin && software_write_enable && fmc_reg[`OFMC_B_ESU])
        fmc_next[`OFMC_B_E] = wd[`OFMC_B_E]; // R18
      if (flash_write_enable_pin && software_write_enable && fmc_reg[`OFMC_B_PSU])
        fmc_next[`OFMC_B_P] = wd[`OFMC_B_P]; // R18
    end
    if (!flash_write_enable_pin || is_user) fmc_next = `OFMC_FMC1_RST; // R11 R8
  end

  // ========================================
  // Register read mux
  always @* begin
    reg_rdata = 32'h00000000;
    if (in_bram) begin
      reg_rdata = {24'h000000, boot_ram[avs_address_in[9:2]]};
    end else begin
      case (rofs)
        `OFMC_OFS_FMC1: reg_rdata = {24'h000000, flash_write_enable_pin, fmc_reg}; // R19
        `OFMC_OFS_EBLK: reg_rdata = {20'h00000, eblk_reg};
        `OFMC_OFS_RAMEMU: reg_rdata = {24'h000000, ramemu_reg};
        `OFMC_OFS_STAT: reg_rdata = {16'h0000, bptr_reg, locked,
          boot_erased_reg, settle_ok, ~idle, fwe_seen_reg, run_mode_reg};
        `OFMC_OFS_SERRX: reg_rdata = {23'h000000, rxv_reg, rxd_reg};
        `OFMC_OFS_BAUD: reg_rdata = {16'h0000, period};
        default: reg_rdata = 32'h00000000;
      endcase
    end
  end

  // ========================================
  // Memories: page latch, overlap RAM, loader RAM
  always @(posedge core_clk_in) begin
    if (clk_en_in) begin
      if (fl_acc && avs_write_in && !ovl_hit)
        page_buf[pg_idx] <= lane_merge(page_buf[pg_idx],
          avs_writedata_in, avs_byteenable_in); // R3
      if (fl_acc && avs_write_in && ovl_hit)
        ovl_ram[ovl_idx] <= lane_merge(ovl_ram[ovl_idx],
          avs_writedata_in, avs_byteenable_in); // R15
      if (rx_valid && is_boot)
        boot_ram[bptr_reg] <= rx_byte; // R13
    end
  end

  // ========================================
  // Mode tracking, protection, erase, bus sequencer
  always @(posedge core_clk_in) begin
    if (srst_in) begin
      // Synchronisers keep running during reset
      if (!flash_write_enable_pin) run_mode_reg <= M_USER; // R7
      else if (md == `OFMC_MD_BOOT) run_mode_reg <= M_BOOT;
      else run_mode_reg <= M_UPROG;
      fwe_seen_reg <= flash_write_enable_pin;
      run_mode_out <= M_USER;
      fmc_reg <= `OFMC_FMC1_RST; // R19
      eblk_reg <= `OFMC_EBLK_RST;
      ramemu_reg <= `OFMC_RAMEMU_RST;
      settle_reg <= 12'h000;
      p_prev_reg <= 1'b0;
      e_prev_reg <= 1'b0;
      boot_erased_reg <= 1'b0;
      page_addr_reg <= 11'h000;
      cnt_reg <= 5'h00;
      rxd_reg <= 8'h00;
      rxv_reg <= 1'b0;
      bptr_reg <= 8'h00;
      state_reg <= S_IDLE;
      avs_readdata_out <= 32'h00000000;
      avs_waitrequest_out <= 1'b1;
      flash_rd_out <= 1'b0;
      flash_wr_out <= 1'b0;
      flash_addr_out <= 18'h00000;
      flash_wdata_out <= 32'h00000000;
      flash_erase_out <= 1'b0;
      flash_erase_blocks_out <= `OFMC_EBLK_RST;
      flash_op_mode_out <= 4'h0;
    end else if (clk_en_in) begin
      fmc_reg <= fmc_next;
      run_mode_out <= run_mode_reg;
      flash_op_mode_out <= {fmc_reg[`OFMC_B_EV], fmc_reg[`OFMC_B_PV],
        fmc_reg[`OFMC_B_E], fmc_reg[`OFMC_B_P]}; // R2
      // Settling count runs while all seven control bits, SWE included, stay clear
      if (fmc_reg != `OFMC_FMC1_RST) settle_reg <= 12'h000;
      else if (!settle_ok) settle_reg <= settle_reg + 12'h001; // R20
      if (!is_boot && flash_write_enable_pin != fwe_seen_reg && settle_ok) begin
        fwe_seen_reg <= flash_write_enable_pin; // R9 R20 R10
        run_mode_reg <= flash_write_enable_pin ? M_UPROG : M_USER;
      end
      if (!flash_write_enable_pin) eblk_reg <= `OFMC_EBLK_RST; // R11
      else if (bus_go && wr_lo && rofs == `OFMC_OFS_EBLK && software_write_enable)
        eblk_reg <= avs_writedata_in[11:0];
      if (bus_go && wr_lo && rofs == `OFMC_OFS_RAMEMU)
        ramemu_reg <= `OFMC_RAMEMU_RST | {4'h0, wd[3:0]}; // R16
      // Erase pulse on rising erase bit
      e_prev_reg <= fmc_reg[`OFMC_B_E];
      flash_erase_out <= 1'b0;
      if (e_rise && flash_write_enable_pin && is_boot) begin
        flash_erase_out <= 1'b1; // R12
        flash_erase_blocks_out <= `OFMC_EBLK_ALL;
        boot_erased_reg <= 1'b1;
      end else if (e_rise && flash_write_enable_pin && eblk_one) begin
        flash_erase_out <= 1'b1; // R4 R5
        flash_erase_blocks_out <= eblk_reg;
      end
      // Received byte flag: new byte wins over read-clear
      if (rx_valid && is_boot) begin
        rxd_reg <= rx_byte;
        rxv_reg <= 1'b1;
        bptr_reg <= bptr_reg + 8'h01;
      end else if (bus_go && avs_read_in && in_reg && !in_bram &&
          rofs == `OFMC_OFS_SERRX) begin
        rxv_reg <= 1'b0;
      end
      flash_rd_out <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          if (idle) p_prev_reg <= fmc_reg[`OFMC_B_P];
          if (p_go) begin
            cnt_reg <= 5'h00;
            state_reg <= S_PROG; // R3
          end else if (req && in_reg) begin
            avs_readdata_out <= reg_rdata;
            avs_waitrequest_out <= 1'b0;
            state_reg <= S_ACK;
          end else if (req && avs_write_in) begin
            if (!ovl_hit) page_addr_reg <= faddr[17:7]; // R3
            avs_waitrequest_out <= 1'b0;
            state_reg <= S_ACK;
          end else if (req && ovl_hit) begin
            avs_readdata_out <= ovl_ram[ovl_idx]; // R15
            avs_waitrequest_out <= 1'b0;
            state_reg <= S_ACK;
          end else if (req && fmc_reg[`OFMC_B_E]) begin
            avs_readdata_out <= `OFMC_ERASED_WORD; // R6
            avs_waitrequest_out <= 1'b0;
            state_reg <= S_ACK;
          end else if (req) begin
            flash_rd_out <= 1'b1; // R1
            flash_addr_out <= faddr;
            cnt_reg <= 5'h00;
            state_reg <= S_FRD;
          end
        end
        S_FRD: begin
          if (cnt_reg[2:0] == `OFMC_FRD_LAT) begin
            avs_readdata_out <= flash_rdata_in; // R1
            avs_waitrequest_out <= 1'b0;
            state_reg <= S_ACK;
          end else begin
            cnt_reg <= cnt_reg + 5'h01;
          end
        end
        S_ACK: begin
          avs_waitrequest_out <= 1'b1;
          state_reg <= S_IDLE;
        end
        S_PROG: begin
          // One word per cycle, whole page in one operation
          flash_wr_out <= 1'b1; // R3
          flash_addr_out <= {page_addr_reg, cnt_reg, 2'b00};
          flash_wdata_out <= page_buf[cnt_reg];
          cnt_reg <= cnt_reg + 5'h01;
          if (cnt_reg == `OFMC_PAGE_LAST) state_reg <= S_ACK;
        end
        default: state_reg <= S_IDLE;
      endcase
      if (state_reg[2]) flash_wr_out <= 1'b0;
    end
  end
endmodule // ofmc_top

// File: verification/ofmc_flash_model.sv
// Behavioural 256-kbyte flash array on the far side of the controller.
// Assumes word addressing from flash_addr_out[17:2].
`timescale 1ns/1ps
module ofmc_flash_model (
  input logic core_clk_in,
  input logic flash_rd_out,
  input logic flash_wr_out,
  input logic [17:0] flash_addr_out,
  input logic [31:0] flash_wdata_out,
  input logic flash_erase_out,
  input logic [11:0] flash_erase_blocks_out,
  output logic [31:0] flash_rdata_in
);
  logic [31:0] mem [int];
  logic [31:0] q_reg = 32'h0;
  logic [1:0] hold_reg = 2'h0;
  logic [11:0] last_mask = 12'h000;
  int n_erase = 0;
  int n_wr = 0;
  int idx;
  assign idx = int'(flash_addr_out[17:2]);
  // ========================================
  // Block map in words
  function automatic int blk_base(input int b);
    if (b < 3) return b * 16384;
    if (b == 3) return 49152;
    return 57344 + (b - 4) * 1024;
  endfunction
  function automatic int blk_size(input int b);
    return (b < 3) ? 16384 : ((b == 3) ? 8192 : 1024);
  endfunction
  // ========================================
  // Array behaviour
  always @(posedge core_clk_in) begin
    if (flash_rd_out) begin
      q_reg <= mem.exists(idx) ? mem[idx] : 32'hffffffff;
      hold_reg <= 2'h3;
    end else if (hold_reg != 2'h0) begin
      hold_reg <= hold_reg - 2'h1;
    end
    if (flash_wr_out) begin
      mem[idx] = flash_wdata_out;
      n_wr++;
    end
    if (flash_erase_out) begin
      n_erase++;
      last_mask = flash_erase_blocks_out;
      for (int b = 0; b < 12; b++) begin
        if (flash_erase_blocks_out[b]) begin
          for (int w = blk_base(b); w < blk_base(b) + blk_size(b); w++)
            mem.delete(w);
        end
      end
    end
  end
  // Data lines stop holding once the read window has passed
  assign flash_rdata_in = (hold_reg != 2'h0) ? q_reg : ~q_reg;
endmodule // ofmc_flash_model

// File: verification/ofmc_top_chk.sv
// Port assertions for the flash mode controller.
// Assumes it is bound to ofmc_top with clk_en_in held high.
`timescale 1ns/1ps
module ofmc_top_chk (
  input logic core_clk_in,
  input logic srst_in,
  input logic avs_read_in,
  input logic avs_write_in,
  input logic avs_waitrequest_out,
  input logic flash_rd_out,
  input logic flash_wr_out,
  input logic flash_erase_out,
  input logic [11:0] flash_erase_blocks_out,
  input logic [3:0] flash_op_mode_out,
  input logic [2:0] run_mode_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (srst_in);
  logic [7:0] wr_run_reg;
  // ========================================
  // Length of the current program burst
  always @(posedge core_clk_in) begin
    if (srst_in || !flash_wr_out) begin
      wr_run_reg <= 8'h00;
    end else begin
      wr_run_reg <= wr_run_reg + 8'h01;
    end
  end
  // ========================================
  // Properties
  chk_answer_short: assert property (!avs_waitrequest_out |=>
    avs_waitrequest_out) else $error("answer longer than one cycle");
  chk_answer_req: assert property (!avs_waitrequest_out |->
    (avs_read_in || avs_write_in)) else $error("answer without request");
  chk_read_lat: assert property (flash_rd_out |-> ##3
    !avs_waitrequest_out) else $error("flash read answer late");
  chk_rd_pulse: assert property (flash_rd_out |=> !flash_rd_out)
    else $error("flash read strobe too long");
  chk_page_len: assert property ($fell(flash_wr_out) |->
    wr_run_reg == 8'h20) else $error("page burst not 32 words");
  chk_user_locked: assert property (run_mode_out == 3'h1 |->
    !flash_wr_out && !flash_erase_out && flash_op_mode_out == 4'h0)
    else $error("program or erase in user mode");
  chk_erase_single: assert property (flash_erase_out &&
    run_mode_out == 3'h2 |-> $onehot(flash_erase_blocks_out))
    else $error("erase mask not one block");
  chk_boot_full: assert property (flash_erase_out &&
    run_mode_out == 3'h4 |-> flash_erase_blocks_out == 12'hfff)
    else $error("boot erase not whole array");
  chk_mode_onehot: assert property ($onehot(run_mode_out))
    else $error("run mode not one-hot");
  chk_op_single: assert property ($onehot0(flash_op_mode_out))
    else $error("several operating modes at once");
  chk_erase_pulse: assert property (flash_erase_out |=> !flash_erase_out)
    else $error("erase strobe too long");
endmodule // ofmc_top_chk

// File: verification/onchip_flash_mode_control_tb_top.sv
// Self-checking bench for ofmc_top with a flash array model.
// Assumes the checker and model files are compiled first.
`timescale 1ns/1ps
module onchip_flash_mode_control_tb_top;
  localparam logic [19:0] REG = 20'h80000;
  logic core_clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic flash_write_enable_pin = 1'b0;
  logic [2:0] md = 3'h0;
  logic [19:0] addr = 20'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata, fwdata, frdata, rd_val;
  logic waitreq, frd, fwr, fer;
  logic [17:0] faddr;
  logic [11:0] fblk;
  logic [3:0] fop;
  logic [2:0] run_mode;
  logic rx = 1'b1;
  logic stx;
  int k;
  logic [15:0] lfsr_reg = 16'hda9f;
  logic [31:0] exp_q [$];
  int n_mismatch = 0;
  int samples_checked = 0;
  ofmc_top u_dut (.core_clk_in(core_clk_in), .srst_in(srst_in),
    .clk_en_in(1'b1), .flash_write_enable_pin_in(flash_write_enable_pin),
    .mode_select_bit2_in(md[2]), .mode_select_bit1_in(md[1]),
    .mode_select_bit0_in(md[0]), .serial_rx_in(rx), .serial_tx_out(stx),
    .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wdata), .avs_byteenable_in(4'hf),
    .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq),
    .flash_rd_out(frd), .flash_wr_out(fwr), .flash_addr_out(faddr),
    .flash_wdata_out(fwdata), .flash_rdata_in(frdata),
    .flash_erase_out(fer), .flash_erase_blocks_out(fblk),
    .flash_op_mode_out(fop), .run_mode_out(run_mode));
  ofmc_flash_model u_flash (.core_clk_in(core_clk_in),
    .flash_rd_out(frd), .flash_wr_out(fwr), .flash_addr_out(faddr),
    .flash_wdata_out(fwdata), .flash_erase_out(fer),
    .flash_erase_blocks_out(fblk), .flash_rdata_in(frdata));
  initial begin
    forever #20 core_clk_in = ~core_clk_in;
  end
  // ========================================
  // Tasks
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic tally_and_finish;
    if (n_mismatch == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [19:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk_in);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    do begin
      @(posedge core_clk_in);
      n++;
    end while (waitreq !== 1'b0 && n < 500);
    if (n >= 500) begin
      n_mismatch++;
      tally_and_finish;
    end else begin
      rd_val = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
    end
  endtask
  task automatic rchk(input string what, input logic [19:0] a,
                      input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(what, rd_val, exp);
  endtask
  // Host side of the boot link: one 8N1 frame, 16 clocks per bit
  task automatic ser_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rx <= f[i];
      repeat (16) @(posedge core_clk_in);
    end
  endtask
  task automatic do_reset(input logic f, input logic [2:0] m);
    @(posedge core_clk_in);
    srst_in <= 1'b1;
    flash_write_enable_pin <= f;
    md <= m;
    repeat (5) @(posedge core_clk_in);
    srst_in <= 1'b0;
    repeat (2) @(posedge core_clk_in);
  endtask
  // ========================================
  // Scenarios
  initial begin
    do_reset(1'b0, 3'h0);
    rchk("fmc1_fwe_low", REG, 32'h0);
    check("run_user", run_mode, 3'h1);
    do_reset(1'b1, 3'h0);
    rchk("fmc1_fwe_high", REG, 32'h80);
    check("run_uprog", run_mode, 3'h2);
    bus(1'b1, REG, 32'h7f);
    rchk("fmc1_gate", REG, 32'hc0);
    bus(1'b1, REG, 32'h42);
    rchk("fmc1_e_gate", REG, 32'hc0);
    for (int i = 0; i < 2; i++) begin
      bus(1'b1, REG, 32'h40 | (32'h4 << i));
      @(posedge core_clk_in);
      check("verify_mode", fop, 32'h4 << i);
    end
    for (int i = 0; i < 32; i++) begin
      lfsr_reg = lfsr_next(lfsr_reg);
      exp_q.push_back({lfsr_reg, ~lfsr_reg});
      bus(1'b1, 20'h38000 + 20'(4 * i), exp_q[i]);
    end
    bus(1'b1, REG, 32'h50);
    bus(1'b1, REG, 32'h51);
    bus(1'b1, REG, 32'h50);
    bus(1'b1, REG, 32'h40);
    check("page_writes", u_flash.n_wr, 32);
    for (int i = 0; i < 32; i++)
      rchk("page_word", 20'h38000 + 20'(4 * i), exp_q[i]);
    bus(1'b1, REG | 20'h4, 32'h10);
    bus(1'b1, REG, 32'h60);
    bus(1'b1, REG, 32'h62);
    bus(1'b1, REG, 32'h60);
    check("erase_count", u_flash.n_erase, 1);
    check("erase_mask", u_flash.last_mask, 12'h010);
    rchk("erased_word", 20'h38000, 32'hffffffff);
    bus(1'b1, REG | 20'h4, 32'h3);
    bus(1'b1, REG, 32'h62);
    bus(1'b1, REG, 32'h60);
    check("multi_mask", u_flash.n_erase, 1);
    bus(1'b1, REG, 32'h40);
    bus(1'b1, REG, 32'h0);
    flash_write_enable_pin <= 1'b0;
    repeat (100) @(posedge core_clk_in);
    check("settle_hold", run_mode, 3'h2);
    repeat (300) @(posedge core_clk_in);
    check("to_user", run_mode, 3'h1);
    bus(1'b1, REG, 32'h40);
    rchk("fmc1_locked", REG, 32'h0);
    rchk("emu_reset", REG | 20'h8, 32'hf0);
    bus(1'b1, REG | 20'h8, 32'h8);
    bus(1'b1, 20'h38004, {lfsr_reg, lfsr_reg});
    rchk("overlay_read", 20'h38004, {lfsr_reg, lfsr_reg});
    bus(1'b1, REG | 20'h8, 32'h0);
    rchk("overlay_off", 20'h38004, 32'hffffffff);
    rchk("unmapped", REG | 20'h18, 32'h0);
    flash_write_enable_pin <= 1'b1;
    repeat (400) @(posedge core_clk_in);
    check("to_uprog", run_mode, 3'h2);
    do_reset(1'b1, 3'h5);
    check("run_boot", run_mode, 3'h4);
    bus(1'b1, REG, 32'h40);
    bus(1'b1, REG, 32'h60);
    bus(1'b1, REG, 32'h62);
    bus(1'b1, REG, 32'h60);
    check("boot_erase", u_flash.last_mask, 12'hfff);
    ser_byte(8'h55);
    k = 0;
    while (stx !== 1'b0 && k < 800) begin
      @(posedge core_clk_in);
      k++;
    end
    k = 0;
    while (stx === 1'b0 && k < 800) begin
      @(posedge core_clk_in);
      k++;
    end
    check("ack_low_cycles", k, 32'h90);
    rchk("bit_period", REG | 20'h14, 32'h10);
    lfsr_reg = lfsr_next(lfsr_reg);
    ser_byte(lfsr_reg[7:0]);
    rchk("rx_byte", REG | 20'h10, {23'h0, 1'b1, lfsr_reg[7:0]});
    rchk("rx_cleared", REG | 20'h10, {24'h0, lfsr_reg[7:0]});
    rchk("loader_ram", REG | 20'h400, {24'h0, lfsr_reg[7:0]});
    tally_and_finish;
  end
endmodule // onchip_flash_mode_control_tb_top

bind ofmc_top ofmc_top_chk u_chk (.core_clk_in, .srst_in, .avs_read_in,
  .avs_write_in, .avs_waitrequest_out, .flash_rd_out, .flash_wr_out,
  .flash_erase_out, .flash_erase_blocks_out, .flash_op_mode_out,
  .run_mode_out);
